// File: src/sas_pkg.sv
// package for the converter sequencer: register map, fields, timing
package sas_pkg;
	// register byte offsets (chosen map)
	localparam logic [7:0] SAS_OFF_CTRL   = 8'h00;
	localparam logic [7:0] SAS_OFF_CFG    = 8'h04;
	localparam logic [7:0] SAS_OFF_STATUS = 8'h08;
	localparam logic [7:0] SAS_OFF_DATA   = 8'h0C;
	localparam logic [7:0] SAS_OFF_WLO    = 8'h10;
	localparam logic [7:0] SAS_OFF_WHI    = 8'h14;
	// ctrl fields
	localparam int SAS_CTRL_EN     = 0;
	localparam int SAS_CTRL_START  = 1;
	localparam int SAS_CTRL_TRG_LO = 2;
	localparam int SAS_CTRL_LJUST  = 4;
	localparam int SAS_CTRL_DONECL = 5;
	localparam int SAS_CTRL_WINCL  = 6;
	// cfg fields
	localparam int SAS_CFG_CH_LO   = 0;
	localparam int SAS_CFG_GAIN_LO = 4;
	localparam int SAS_CFG_DIFF_LO = 8;
	// status fields
	localparam int SAS_ST_DONE = 0;
	localparam int SAS_ST_WIN  = 1;
	localparam int SAS_ST_BUSY = 2;
	// reset values
	localparam logic [6:0]  SAS_CTRL_RST = 7'h00;
	localparam logic [11:0] SAS_CFG_RST  = 12'h000;
	localparam logic [11:0] SAS_WLO_RST  = 12'hFFF;
	localparam logic [11:0] SAS_WHI_RST  = 12'h000;
	// timing: 100 ksps over a 100 MHz clock
	localparam int SAS_CLK_HZ       = 100_000_000;
	localparam int SAS_RATE_SPS     = 100_000;
	localparam int SAS_SAMPLE_CYC   = SAS_CLK_HZ / SAS_RATE_SPS;
	localparam int SAS_CHANNELS     = 9;
	localparam logic [3:0] SAS_TEMP_CH = 4'h8;
	localparam logic [2:0] SAS_GAIN_MAX = 3'h5;
	typedef enum logic [1:0] {SAS_TRG_SW, SAS_TRG_T2, SAS_TRG_T3, SAS_TRG_EXT} sas_trig_t;
	typedef enum logic [1:0] {SAS_IDLE, SAS_CONV} sas_state_t;
endpackage

// File: src/sas_adc_seq.sv
// converter sequencer: apb registers, trigger select, result latch, window compare
// Notes on behaviour
// [RULE1] nine inputs: eight external plus temperature
// [RULE2] each external pair single-ended or differential
// [RULE3] gain powers of two, half to sixteen
// [RULE4] start by software, timer2, timer3, external
// [RULE5] external start comes from pin mapping
// [RULE6] completion sets flag and interrupt request
// [RULE7] result of 12 or 10 bits latched
// [RULE8] software picks right or left justify
// [RULE9] window interrupt only inside programmed window
// [RULE10] software shutdown stops converter
// [RULE11] sequencing sustains one hundred thousand samples/s
// [RULE12] converter ignores debugger halt
// [RULE13] busy from trigger to latch; ignore retriggers
`timescale 1ns/1ns
`default_nettype none
module sas_adc_seq
	import sas_pkg::*;
#(
	parameter int RES_BITS   = 12,
	parameter int SAMPLE_CYC = SAS_SAMPLE_CYC
) (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// trigger sources and debug halt
	input  wire logic        timer2_ovf,
	input  wire logic        timer3_ovf,
	input  wire logic        ext_start,
	input  wire logic        debug_halt,
	// conversion core
	output logic      [3:0]  mux_sel,
	output logic      [3:0]  pair_diff,
	output logic      [2:0]  gain_sel,
	output logic             conv_power,
	output logic             conv_start,
	input  wire logic        conv_done,
	input  wire logic [RES_BITS-1:0] conv_data,
	// events
	output logic             done_irq,
	output logic             win_irq,
	output logic             busy
);
	////////////////////////////////////////////////////////////////////////
	logic [6:0]  ctrl_q;
	logic [11:0] cfg_q;
	logic [11:0] wlo_q, whi_q;
	logic [15:0] data_q;
	logic        done_q, win_q;
	sas_state_t  state_q;
	logic [$clog2(SAMPLE_CYC+1)-1:0] gap_q;
	logic        wr, start_sw, trig, accept, latch, in_win;
	logic [11:0] res12;
	sas_trig_t   trg_sel;

	assign wr      = psel & penable & pwrite;
	assign pready  = 1'b1;
	assign pslverr = psel & penable & (paddr > SAS_OFF_WHI || paddr[1:0] != 2'h0);
	assign start_sw = wr && paddr == SAS_OFF_CTRL && pwdata[SAS_CTRL_START];
	assign trg_sel = sas_trig_t'(ctrl_q[SAS_CTRL_TRG_LO +: 2]);

	////////////////////////////////////////////////////////////////////////
	// configuration registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= SAS_CTRL_RST;
			cfg_q  <= SAS_CFG_RST;
			wlo_q  <= SAS_WLO_RST;
			whi_q  <= SAS_WHI_RST;
		end else if (wr) begin
			unique case (paddr)
				SAS_OFF_CTRL: ctrl_q <= {2'b00, pwdata[4:2], 1'b0, pwdata[0]};
				SAS_OFF_CFG: begin
					cfg_q[3:0]  <= (pwdata[3:0] > SAS_TEMP_CH) ? SAS_TEMP_CH : pwdata[3:0]; // [RULE1]
					cfg_q[6:4]  <= (pwdata[6:4] > SAS_GAIN_MAX) ? SAS_GAIN_MAX : pwdata[6:4]; // [RULE3]
					cfg_q[7]    <= 1'b0;
					cfg_q[11:8] <= pwdata[11:8]; // [RULE2]
				end
				SAS_OFF_WLO: wlo_q <= pwdata[11:0];
				SAS_OFF_WHI: whi_q <= pwdata[11:0];
				default: ;
			endcase
		end
	end

	// analog side controls
	assign mux_sel    = cfg_q[SAS_CFG_CH_LO +: 4]; // [RULE1]
	assign pair_diff  = cfg_q[SAS_CFG_DIFF_LO +: 4]; // [RULE2]
	assign gain_sel   = cfg_q[SAS_CFG_GAIN_LO +: 3]; // [RULE3]
	assign conv_power = ctrl_q[SAS_CTRL_EN]; // [RULE10]

	////////////////////////////////////////////////////////////////////////
	// trigger select; ext_start is the pin routed by the pin-mapping network
	always_comb begin
		trig = 1'b0;
		unique case (trg_sel) // [RULE4]
			SAS_TRG_SW:  trig = start_sw;
			SAS_TRG_T2:  trig = timer2_ovf;
			SAS_TRG_T3:  trig = timer3_ovf;
			SAS_TRG_EXT: trig = ext_start; // [RULE5]
		endcase
	end
	// debug_halt deliberately unused in gating: converter keeps running
	assign accept = trig && conv_power && state_q == SAS_IDLE && gap_q == '0; // [RULE13] [RULE12]
	assign latch  = state_q == SAS_CONV && conv_done;

	// sequencer; gap counter holds the sample period so the rate is capped at 100 ksps
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= SAS_IDLE;
			gap_q   <= '0;
		end else begin
			if (accept)
				gap_q <= ($clog2(SAMPLE_CYC+1))'(SAMPLE_CYC - 1); // [RULE11]
			else if (gap_q != '0)
				gap_q <= gap_q - 1'b1;
			if (!conv_power)
				state_q <= SAS_IDLE; // [RULE10]
			else if (accept)
				state_q <= SAS_CONV;
			else if (latch)
				state_q <= SAS_IDLE;
		end
	end
	assign conv_start = accept;
	assign busy       = state_q == SAS_CONV; // [RULE13]

	////////////////////////////////////////////////////////////////////////
	// result latch, justify and window compare on the 12-bit scale
	assign res12  = 12'(conv_data) << (12 - RES_BITS);
	assign in_win = res12 >= wlo_q && res12 <= whi_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			data_q <= 16'h0000;
		else if (latch)
			data_q <= ctrl_q[SAS_CTRL_LJUST] ? {res12, 4'h0} : 16'(conv_data); // [RULE7] [RULE8]
	end

	// sticky flags: a new event wins over a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_q <= 1'b0;
			win_q  <= 1'b0;
		end else begin
			if (latch)
				done_q <= 1'b1; // [RULE6]
			else if (wr && paddr == SAS_OFF_CTRL && pwdata[SAS_CTRL_DONECL])
				done_q <= 1'b0;
			if (latch && in_win)
				win_q <= 1'b1; // [RULE9]
			else if (wr && paddr == SAS_OFF_CTRL && pwdata[SAS_CTRL_WINCL])
				win_q <= 1'b0;
		end
	end
	assign done_irq = done_q; // [RULE6]
	assign win_irq  = win_q;

	////////////////////////////////////////////////////////////////////////
	// read mux
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (psel && !penable && !pwrite) begin
			unique case (paddr)
				SAS_OFF_CTRL:   prdata <= {25'h0, ctrl_q};
				SAS_OFF_CFG:    prdata <= {20'h0, cfg_q};
				SAS_OFF_STATUS: prdata <= {29'h0, busy, win_q, done_q};
				SAS_OFF_DATA:   prdata <= {16'h0, data_q};
				SAS_OFF_WLO:    prdata <= {20'h0, wlo_q};
				SAS_OFF_WHI:    prdata <= {20'h0, whi_q};
				default:        prdata <= 32'h0000_0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// assertions
	// sequencer and triggers
	a_busy_until_latch: assert property ( // [RULE13]
		@(posedge pclk) disable iff (!presetn)
		busy && !conv_done && conv_power |=> busy
	) else $error("busy dropped before result latched");

	a_busy_follows: assert property ( // [RULE13]
		@(posedge pclk) disable iff (!presetn)
		conv_start |=> busy
	) else $error("busy not raised after start");

	a_no_retrigger: assert property ( // [RULE13]
		@(posedge pclk) disable iff (!presetn)
		busy |-> !conv_start
	) else $error("start issued while busy");

	a_start_source: assert property ( // [RULE4]
		@(posedge pclk) disable iff (!presetn)
		conv_start |-> trig
	) else $error("start without selected trigger");

	a_trig_soft: assert property ( // [RULE4]
		@(posedge pclk) disable iff (!presetn)
		trg_sel == SAS_TRG_SW && start_sw && conv_power && state_q == SAS_IDLE && gap_q == '0 |-> conv_start
	) else $error("software start ignored");

	a_trig_timer3: assert property ( // [RULE4]
		@(posedge pclk) disable iff (!presetn)
		trg_sel == SAS_TRG_T3 && timer3_ovf && conv_power && state_q == SAS_IDLE && gap_q == '0 |-> conv_start
	) else $error("timer3 start ignored");

	a_trig_ext: assert property ( // [RULE5]
		@(posedge pclk) disable iff (!presetn)
		trg_sel == SAS_TRG_EXT && ext_start && conv_power && state_q == SAS_IDLE && gap_q == '0 |-> conv_start
	) else $error("external start ignored");

	a_halt_runs: assert property ( // [RULE12]
		@(posedge pclk) disable iff (!presetn)
		debug_halt && trg_sel == SAS_TRG_T2 && timer2_ovf && conv_power && !busy && gap_q == '0 |-> conv_start
	) else $error("halt stalled the converter");

	a_rate_cap: assert property ( // [RULE11]
		@(posedge pclk) disable iff (!presetn)
		conv_start |=> !conv_start [*8]
	) else $error("starts too close together");

	a_rate_gap: assert property ( // [RULE11]
		@(posedge pclk) disable iff (!presetn)
		conv_start |=> gap_q != '0
	) else $error("sample gap not loaded");

	a_shutdown_idle: assert property ( // [RULE10]
		@(posedge pclk) disable iff (!presetn)
		!conv_power |-> !conv_start
	) else $error("start while shut down");

	a_shutdown_abort: assert property ( // [RULE10]
		@(posedge pclk) disable iff (!presetn)
		!conv_power |=> !busy
	) else $error("busy while shut down");

	// configuration
	a_gain_range: assert property ( // [RULE3]
		@(posedge pclk) disable iff (!presetn)
		gain_sel <= SAS_GAIN_MAX && mux_sel <= SAS_TEMP_CH
	) else $error("gain or channel out of range");

	a_gain_write: assert property ( // [RULE3]
		@(posedge pclk) disable iff (!presetn)
		wr && paddr == SAS_OFF_CFG && pwdata[6:4] <= SAS_GAIN_MAX |=> gain_sel == $past(pwdata[6:4])
	) else $error("gain write lost");

	a_temp_channel: assert property ( // [RULE1]
		@(posedge pclk) disable iff (!presetn)
		wr && paddr == SAS_OFF_CFG && pwdata[3:0] >= SAS_TEMP_CH |=> mux_sel == SAS_TEMP_CH
	) else $error("temperature channel not selected");

	a_pair_mode: assert property ( // [RULE2]
		@(posedge pclk) disable iff (!presetn)
		wr && paddr == SAS_OFF_CFG |=> pair_diff == $past(pwdata[11:8])
	) else $error("pair mode write lost");

	// result and flags
	a_data_right: assert property ( // [RULE7]
		@(posedge pclk) disable iff (!presetn)
		latch && !ctrl_q[SAS_CTRL_LJUST] |=> data_q == 16'($past(conv_data))
	) else $error("right justified result wrong");

	a_left_justify: assert property ( // [RULE8]
		@(posedge pclk) disable iff (!presetn)
		latch && ctrl_q[SAS_CTRL_LJUST] |=> data_q[3:0] == 4'h0 && data_q[15:4] == $past(res12)
	) else $error("left justified result wrong");

	a_done_sets_flag: assert property ( // [RULE6]
		@(posedge pclk) disable iff (!presetn)
		latch |=> done_irq
	) else $error("done flag not raised after completion");

	a_done_clear: assert property ( // [RULE6]
		@(posedge pclk) disable iff (!presetn)
		wr && paddr == SAS_OFF_CTRL && pwdata[SAS_CTRL_DONECL] && !latch |=> !done_irq
	) else $error("done flag not cleared");

	a_win_only_inside: assert property ( // [RULE9]
		@(posedge pclk) disable iff (!presetn)
		$rose(win_irq) |-> $past(latch) && $past(in_win)
	) else $error("window flag set outside window");

	a_win_outside: assert property ( // [RULE9]
		@(posedge pclk) disable iff (!presetn)
		latch && !in_win && !win_q |=> !win_irq
	) else $error("window flag raised by outside result");
endmodule // sas_adc_seq
`default_nettype wire

// File: verif/sas_core_model.sv
// conversion core model: answers each accepted start after a fixed delay
`timescale 1ns/1ns
`default_nettype none
module sas_core_model #(
	parameter int DLY = 8
) (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// core side
	input  wire logic        conv_start,
	input  wire logic        conv_power,
	input  wire logic [3:0]  mux_sel,
	output logic             conv_done,
	output logic      [11:0] conv_data
);
	int          cnt_q;
	logic [11:0] res_q;
	// data is inverted outside the done pulse so a stale value never passes
	assign conv_data = conv_done ? res_q : ~res_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 0;
			res_q <= 12'h000;
			conv_done <= 1'b0;
		end else begin
			conv_done <= conv_power && cnt_q == 1;
			if (conv_start && conv_power) begin
				cnt_q <= DLY;
				res_q <= {4'hA, 4'h0, mux_sel};
			end else if (cnt_q > 0) begin
				cnt_q <= cnt_q - 1;
			end
		end
	end
endmodule // sas_core_model
`default_nettype wire

// File: verif/tb_sas_adc_seq.sv
// testbench for the converter sequencer
`timescale 1ns/1ns
`default_nettype none
module tb_sas_adc_seq;
	import sas_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, timer2_ovf, timer3_ovf, ext_start, debug_halt;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic        pready, pslverr, conv_power, conv_start, conv_done, done_irq, win_irq, busy;
	logic [3:0]  mux_sel, pair_diff;
	logic [2:0]  gain_sel;
	logic [11:0] conv_data;
	int          errors, checked;
	int          starts = 0;
	sas_adc_seq #(.RES_BITS(12), .SAMPLE_CYC(10)) sas_adc_seq_inst (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .timer2_ovf(timer2_ovf),
		.timer3_ovf(timer3_ovf), .ext_start(ext_start), .debug_halt(debug_halt), .mux_sel(mux_sel),
		.pair_diff(pair_diff), .gain_sel(gain_sel), .conv_power(conv_power), .conv_start(conv_start),
		.conv_done(conv_done), .conv_data(conv_data), .done_irq(done_irq), .win_irq(win_irq), .busy(busy));
	sas_core_model sas_core_model_inst (.pclk(pclk), .presetn(presetn), .conv_start(conv_start),
		.conv_power(conv_power), .mux_sel(mux_sel), .conv_done(conv_done), .conv_data(conv_data));
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk) if (conv_start === 1'b1) starts++;
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
		int n;
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		r = prdata;
		e = pslverr;
		{psel, penable} <= 2'b00;
		if (n >= 20) begin
			errors++;
			print_verdict();
		end
	endtask
	task automatic limit(input int n, input int lim);
		if (n >= lim) begin
			errors++;
			print_verdict();
		end
	endtask
	task automatic fire(input logic [1:0] ts, input logic en);
		logic [31:0] r;
		logic        e;
		if (ts == 2'h0) apb(1'b1, SAS_OFF_CTRL, {30'h0, 1'b1, en}, r, e);
		else begin
			@(posedge pclk);
			{timer2_ovf, timer3_ovf, ext_start} <= {ts == 2'h1, ts == 2'h2, ts == 2'h3};
			@(posedge pclk);
			{timer2_ovf, timer3_ovf, ext_start} <= 3'h0;
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_regs();
		logic [31:0] r;
		logic        e;
		apb(1'b0, SAS_OFF_WLO, 32'h0, r, e);
		chk("wlo reset", r, 32'h00000FFF);
		apb(1'b0, 8'h18, 32'h0, r, e);
		chk("unmapped data", r, 32'h0000_0000);
		chk("unmapped err", e, 1'b1);
		apb(1'b1, SAS_OFF_CFG, 32'h0000_0A7F, r, e);
		@(negedge pclk);
		chk("cfg ports", {pair_diff, gain_sel, mux_sel}, {4'hA, 3'h5, 4'h8});
		$display("test regs done");
	endtask
	task automatic t_conv(input logic [1:0] ts, input logic lj, input logic [11:0] lo, input logic [11:0] hi);
		logic [31:0] r;
		logic        e, in_win;
		int          n, s0;
		in_win = lo <= 12'hA08 && hi >= 12'hA08;
		apb(1'b1, SAS_OFF_WLO, {20'h0, lo}, r, e);
		apb(1'b1, SAS_OFF_WHI, {20'h0, hi}, r, e);
		apb(1'b1, SAS_OFF_CTRL, {25'h0, 2'b11, lj, ts, 2'b01}, r, e);
		@(negedge pclk);
		chk("power on", conv_power, 1'b1);
		repeat (12) @(posedge pclk);
		s0 = starts;
		fire(ts, 1'b1);
		for (n = 0; n < 20 && busy !== 1'b1; n++) @(posedge pclk);
		limit(n, 20);
		fire(ts, 1'b1);
		for (n = 0; n < 50 && busy !== 1'b0; n++) @(posedge pclk);
		limit(n, 50);
		chk("one start", starts - s0, 1);
		apb(1'b0, SAS_OFF_STATUS, 32'h0, r, e);
		chk("status", r[2:0], {1'b0, in_win, 1'b1});
		chk("irqs", {done_irq, win_irq}, {1'b1, in_win});
		apb(1'b0, SAS_OFF_DATA, 32'h0, r, e);
		chk("data", r, lj ? 32'h0000_A080 : 32'h0000_0A08);
		$display("test conv %0d done", ts);
	endtask
	task automatic t_off();
		logic [31:0] r;
		logic        e;
		int          s0;
		apb(1'b1, SAS_OFF_CTRL, 32'h0000_0060, r, e);
		s0 = starts;
		fire(2'h0, 1'b0);
		repeat (15) @(posedge pclk);
		chk("shutdown power", conv_power, 1'b0);
		chk("shutdown busy", busy, 1'b0);
		chk("shutdown done", done_irq, 1'b0);
		chk("shutdown starts", starts - s0, 0);
		$display("test off done");
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{timer2_ovf, timer3_ovf, ext_start, debug_halt} = 4'h0;
		{errors, checked} = '0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		debug_halt <= 1'b1;
		for (int i = 0; i < 4; i++) t_conv(i[1:0], i[0], i[1] ? 12'hA08 : 12'hA09, i[1] ? 12'hA08 : 12'hFFF);
		t_off();
		print_verdict();
	end
	initial begin
		#500000;
		errors++;
		print_verdict();
	end
endmodule // tb_sas_adc_seq
`default_nettype wire
